//--- hw/buck_hysteretic.sv
// Hysteretic step-down regulator switch control
`timescale 1ns/1ps
module buck_hysteretic
  import fault_prot_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        voltSelect,
  input  wire logic [15:0] vregMv,
  output logic             highSideOn
);

  typedef struct packed {
    logic on;
  } buck_s;

  buck_s st_r;
  buck_s st_nxt;
  logic [15:0] target;

  // ------------------------------------------------------------
  // Switch decision
  // ------------------------------------------------------------
  // Target chosen by select bit
  always_comb
  begin
    target = voltSelect ? VREG_3V3_MV : VREG_5V_MV; // R10
    st_nxt = st_r;
    if (vregMv <= target - VREG_HYS_MV)
      st_nxt.on = 1'b1; // R11
    else if (vregMv >= target)
      st_nxt.on = 1'b0; // R11
  end

  // Register; between the two bounds the switch keeps its state
  always_ff @(posedge clock)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign highSideOn = st_r.on;

endmodule : buck_hysteretic

//--- hw/fault_prot_pkg.sv
// Shared constants and types for the motor-driver fault-protection block
package fault_prot_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ            = 125;
  localparam int unsigned LOCK_OFF_S         = 5;   // Lock release interval, seconds
  localparam longint unsigned LOCK_OFF_CYCLES = longint'(LOCK_OFF_S) * CLK_MHZ * 1000000;
  localparam int unsigned VSUP_SAMPLE_US     = 100; // Supply sampling period, microseconds
  localparam int unsigned VSUP_SAMPLE_CYCLES = VSUP_SAMPLE_US * CLK_MHZ;

  // ------------------------------------------------------------
  // Thresholds
  // ------------------------------------------------------------
  localparam int unsigned TSDN_C         = 150; // Shutdown temperature, degC
  localparam int unsigned TSDN_HYS_C     = 10;  // Hysteresis, degC
  localparam int unsigned IOC_LIMIT_A    = 4;   // Overcurrent limit, A

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] STATUS_ADDR    = 8'h10;
  localparam logic [7:0] CURRENT_ADDR   = 8'h11;
  localparam logic [7:0] SUPPLY_ADDR    = 8'h12;
  localparam logic [7:0] CONTROL_ADDR   = 8'h13;
  localparam logic [7:0] HOSTCFG_LO_ADDR = 8'h14;
  localparam logic [7:0] HOSTCFG_HI_ADDR = 8'h15;
  localparam int unsigned OVER_TEMP_BIT  = 7;
  localparam int unsigned SLEEP_BIT      = 6;
  localparam int unsigned OVER_CURR_BIT  = 5;
  localparam int unsigned ROTOR_LOCK_BIT = 4;
  localparam int unsigned REASON_LSB     = 0;
  localparam int unsigned REASON_W       = 4;
  localparam int unsigned CTRL_VSEL_BIT  = 0;
  localparam int unsigned CTRL_REGMODE_BIT = 1;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // Fault reason codes
  localparam logic [3:0] REASON_NONE    = 4'h0;
  localparam logic [3:0] REASON_LOCK    = 4'h1;

  // Regulator targets in millivolts and hysteresis
  localparam logic [15:0] VREG_5V_MV    = 16'h1388; // 5000 mV
  localparam logic [15:0] VREG_3V3_MV   = 16'h0CE4; // 3300 mV
  localparam logic [15:0] VREG_HYS_MV   = 16'h0032; // 50 mV

  // Configuration width
  localparam int unsigned CFG_W         = 16;

  typedef enum logic [3:0] {
    LOAD    = 4'b0001,
    RUN     = 4'b0010,
    LOCKWT  = 4'b0100,
    SLEEPST = 4'b1000
  } drive_state_e;

endpackage : fault_prot_pkg

//--- hw/motor_fault_protect.sv
// Fault protection, status register and configuration load for the motor driver
// What this block does
// R01: Stop all drive while temperature is above the shutdown limit.
// R02: Resume after shutdown only when temperature falls below limit minus hysteresis.
// R03: Over-temperature flag, status bit 7 at 0x10, high during shutdown.
// R04: Lock out at falling undervoltage; restart only at rising threshold.
// R05: Overcurrent puts every driver in high impedance while it persists.
// R06: Overcurrent flag, status bit 5, set during overcurrent.
// R07: Rotor lock stops the drive at once.
// R08: Restart after release interval; repeat while lock is detected again.
// R09: Rotor-locked flag bit 4 and fault reason field set during lock.
// R10: Regulator target 5 V with select zero, 3.3 V with one.
// R11: High-side switch on at drop by hysteresis, off at target.
// R12: Load non-volatile configuration after power-on and each sleep exit.
// R13: In register mode host-written values override non-volatile settings.
// R14: Sample phase current continuously, supply periodically; both readable.
// R15: Release interval a parameter; fault inputs are synchronized comparator bits.
// R16: Status flags read-only, each tracks its live condition.
`timescale 1ns/1ps
module motor_fault_protect
  import fault_prot_pkg::*;
#(
  parameter longint unsigned LOCK_OFF_COUNT = LOCK_OFF_CYCLES // R15
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             tempAboveLimit,
  input  wire logic             tempBelowRecover,
  input  wire logic             supplyBelowFalling,
  input  wire logic             supplyAboveRising,
  input  wire logic             phaseOverCurrent,
  input  wire logic             rotorLockDetect,
  input  wire logic             sleepRequest,
  input  wire logic [7:0]       phaseCurrent,
  input  wire logic [7:0]       supplyVoltage,
  input  wire logic [15:0]      vregMv,
  input  wire logic [CFG_W-1:0] nvConfig,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  output logic      [7:0]       regRdata,
  output logic                  driveEnable,
  output logic                  driverHighZ,
  output logic                  highSideOn,
  output logic      [CFG_W-1:0] workingConfig,
  output logic                  nvLoadStrobe
);

  // Block state apart from the regulator switch, registered in one place
  typedef struct packed {
    drive_state_e     state;
    logic             over_temperature_flag;
    logic             underVolt;
    logic [39:0]      lockCnt;
    logic [15:0]      sampleCnt;
    logic [7:0]       curSample;
    logic [7:0]       supSample;
    logic [7:0]       control;
    logic [CFG_W-1:0] nvCopy;
    logic [CFG_W-1:0] hostCfg;
    logic             nvLoad;
    logic [7:0]       rdata;
  } fault_s;

  fault_s st_r;
  fault_s st_nxt;
  logic   regMode;
  logic   lockActive;
  logic   faultStop;

  // Decoded views of the state record
  assign regMode    = st_r.control[CTRL_REGMODE_BIT];
  assign lockActive = (st_r.state == LOCKWT);

  // ------------------------------------------------------------
  // Fault summary
  // ------------------------------------------------------------
  // Overcurrent stays combinational so the bridge floats the same cycle
  assign faultStop = st_r.over_temperature_flag || st_r.underVolt || phaseOverCurrent; // R01 R04 R05

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // Inputs arrive already synchronized, so they are used directly
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.nvLoad = 1'b0;

    // Thermal shutdown latch with hysteresis
    if (tempAboveLimit) // R15
      st_nxt.over_temperature_flag = 1'b1; // R01
    else if (tempBelowRecover)
      st_nxt.over_temperature_flag = 1'b0; // R02

    // Undervoltage latch between falling and rising comparators
    if (supplyBelowFalling)
      st_nxt.underVolt = 1'b1; // R04
    else if (supplyAboveRising)
      st_nxt.underVolt = 1'b0; // R04

    // Current every cycle, supply on a slow tick
    // Supply value may lag by up to one sample period
    st_nxt.curSample = phaseCurrent; // R14
    if (st_r.sampleCnt == 16'(VSUP_SAMPLE_CYCLES - 1))
    begin
      st_nxt.sampleCnt = '0;
      st_nxt.supSample = supplyVoltage; // R14
    end
    else
      st_nxt.sampleCnt = st_r.sampleCnt + 16'h0001;

    case (st_r.state)
      LOAD:
      begin
        // Copy lands on the same edge that lets the drive start
        st_nxt.nvCopy = nvConfig; // R12
        st_nxt.nvLoad = 1'b1;
        st_nxt.state  = RUN;
      end
      RUN:
      begin
        // Sleep takes priority over a fresh lock
        if (sleepRequest)
          st_nxt.state = SLEEPST;
        else if (rotorLockDetect)
        begin
          st_nxt.state   = LOCKWT; // R07
          st_nxt.lockCnt = '0;
        end
      end
      LOCKWT:
      begin
        // Relock in RUN re-enters this wait, giving the repeating cycle
        // Sleep is not honoured until the interval ends
        if (st_r.lockCnt >= 40'(LOCK_OFF_COUNT - 1))
          st_nxt.state = RUN; // R08
        else
          st_nxt.lockCnt = st_r.lockCnt + 40'h00_0000_0001;
      end
      SLEEPST:
      begin
        // Wake passes through LOAD so settings refresh
        if (!sleepRequest)
          st_nxt.state = LOAD; // R12
      end
      default: st_nxt.state = LOAD;
    endcase

    // Control and host-setting bytes only; status and measurements ignore writes
    if (regWrite)
    begin
      case (regAddr)
        CONTROL_ADDR:    st_nxt.control       = regWdata;
        HOSTCFG_LO_ADDR: st_nxt.hostCfg[7:0]  = regWdata; // R13
        HOSTCFG_HI_ADDR: st_nxt.hostCfg[15:8] = regWdata; // R13
        default:         st_nxt.control       = st_r.control; // R16
      endcase
    end

    // Read data registered on the read strobe
    if (regRead)
    begin
      case (regAddr)
        // Status bits mirror live state, never stored writes
        STATUS_ADDR:
        begin
          st_nxt.rdata = '0;
          st_nxt.rdata[OVER_TEMP_BIT]  = st_r.over_temperature_flag; // R03 R16
          st_nxt.rdata[SLEEP_BIT]      = (st_r.state == SLEEPST);
          st_nxt.rdata[OVER_CURR_BIT]  = phaseOverCurrent; // R06 R16
          st_nxt.rdata[ROTOR_LOCK_BIT] = lockActive; // R09 R16
          st_nxt.rdata[REASON_LSB +: REASON_W] = lockActive ? REASON_LOCK : REASON_NONE; // R09
        end
        // Measurements as last captured
        CURRENT_ADDR:    st_nxt.rdata = st_r.curSample; // R14
        SUPPLY_ADDR:     st_nxt.rdata = st_r.supSample; // R14
        CONTROL_ADDR:    st_nxt.rdata = st_r.control;
        HOSTCFG_LO_ADDR: st_nxt.rdata = st_r.hostCfg[7:0];
        HOSTCFG_HI_ADDR: st_nxt.rdata = st_r.hostCfg[15:8];
        default:         st_nxt.rdata = READ_UNMAPPED;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Reset enters LOAD so the configuration copy runs at power-on
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      // Flags, counters and samples clear; control comes up at 5 V, NV mode
      st_r         <= '0;
      st_r.state   <= LOAD;
      st_r.control <= CONTROL_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Any fault stops the drive; overcurrent also floats the bridge
  assign driveEnable   = (st_r.state == RUN) && !faultStop; // R01 R04 R07
  assign driverHighZ   = phaseOverCurrent; // R05
  assign workingConfig = regMode ? st_r.hostCfg : st_r.nvCopy; // R13
  assign nvLoadStrobe  = st_r.nvLoad;
  assign regRdata      = st_r.rdata;

  // Regulator switch control follows the select bit of the control register
  buck_hysteretic uBuck (
    .clock      (clock),
    .rst        (rst),
    .voltSelect (st_r.control[CTRL_VSEL_BIT]),
    .vregMv     (vregMv),
    .highSideOn (highSideOn)
  );

endmodule : motor_fault_protect

//--- verif/host_model.sv
// Host side of the register bus
`timescale 1ns/1ps
module host_model
(
  input  wire logic       clock,
  output logic            regWrite = 1'b0,
  output logic            regRead  = 1'b0,
  output logic      [7:0] regAddr  = 8'h00,
  output logic      [7:0] regWdata = 8'h00,
  input  wire logic [7:0] regRdata
);
  // One-cycle strobe; released lines get the inverse so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clock);
    regWrite <= w;
    regRead  <= !w;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
    #1 q = regRdata;
  endtask : xfer
endmodule : host_model

//--- verif/motor_fault_checker.sv
// Concurrent checks on the fault-protection block ports
`timescale 1ns/1ps
module motor_fault_checker
  import fault_prot_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       tempAboveLimit,
  input wire logic       tempBelowRecover,
  input wire logic       supplyBelowFalling,
  input wire logic       supplyAboveRising,
  input wire logic       phaseOverCurrent,
  input wire logic       rotorLockDetect,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdata,
  input wire logic       driveEnable,
  input wire logic       driverHighZ,
  input wire logic       nvLoadStrobe
);
  logic otShadow_r;
  logic uvShadow_r;
  // Shadow latches with set winning, so a clear never hides a fresh fault
  always_ff @(posedge clock)
  begin
    otShadow_r <= !rst && (tempAboveLimit || (otShadow_r && !tempBelowRecover));
    uvShadow_r <= !rst && (supplyBelowFalling || (uvShadow_r && !supplyAboveRising));
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_OT_STOP: assert property (
    otShadow_r |-> !driveEnable) else $error("hot drive");
  AST_UV_LOCK: assert property (
    uvShadow_r |-> !driveEnable) else $error("uv drive");
  AST_OC_HIGHZ: assert property (
    phaseOverCurrent |-> driverHighZ && !driveEnable) else $error("oc");
  AST_HIGHZ_CAUSE: assert property (
    driverHighZ |-> phaseOverCurrent) else $error("stray hz");
  AST_LOCK_STOP: assert property (
    driveEnable && rotorLockDetect |=> !driveEnable [*8]) else $error("lk");
  AST_OT_FLAG: assert property (
    regRead && regAddr == STATUS_ADDR |=> regRdata[OVER_TEMP_BIT] == $past(otShadow_r))
    else $error("hot flag");
  AST_OC_FLAG: assert property (
    regRead && regAddr == STATUS_ADDR |=> regRdata[OVER_CURR_BIT] == $past(phaseOverCurrent))
    else $error("oc flag");
  AST_NV_LOAD: assert property (
    $fell(rst) |=> nvLoadStrobe ##1 !nvLoadStrobe) else $error("load");
  // A driving bridge means no lock wait, so flag and reason read clear
  AST_LOCK_FLAG: assert property (
    regRead && regAddr == STATUS_ADDR && driveEnable |=> !regRdata[ROTOR_LOCK_BIT]
    && regRdata[REASON_LSB +: REASON_W] == REASON_NONE) else $error("lock flag");
  cover property (driveEnable && rotorLockDetect);
  cover property (phaseOverCurrent && regRead);
  cover property (nvLoadStrobe && !$past(rst));
endmodule : motor_fault_checker
bind motor_fault_protect motor_fault_checker uChk
(
  .clock, .rst, .tempAboveLimit, .tempBelowRecover, .supplyBelowFalling, .supplyAboveRising,
  .phaseOverCurrent, .rotorLockDetect, .regRead, .regAddr, .regRdata, .driveEnable,
  .driverHighZ, .nvLoadStrobe
);

//--- verif/tb.sv
// Self-checking bench for the motor fault-protection block
`timescale 1ns/1ps
module tb
  import fault_prot_pkg::*;
;
  localparam longint unsigned LK = 20; // Short release interval keeps the run brief
  logic        clock = 1'b0, rst = 1'b1, tempAboveLimit = 1'b0, tempBelowRecover = 1'b1;
  logic        supplyBelowFalling = 1'b0, supplyAboveRising = 1'b1, phaseOverCurrent = 1'b0;
  logic        rotorLockDetect = 1'b0, sleepRequest = 1'b0;
  logic [7:0]  phaseCurrent = 8'h5C, supplyVoltage = 8'h9A, regAddr, regWdata, regRdata, rdv;
  logic [15:0] vregMv = VREG_5V_MV, nvConfig = 16'h5A3C, workingConfig;
  logic        regWrite, regRead, driveEnable, driverHighZ, highSideOn, nvLoadStrobe;
  int          err_total = 0, checks_done = 0, cyc = 0, n;
  motor_fault_protect #(.LOCK_OFF_COUNT(LK)) u_dut
  (
    .clock, .rst, .tempAboveLimit, .tempBelowRecover, .supplyBelowFalling,
    .supplyAboveRising, .phaseOverCurrent, .rotorLockDetect, .sleepRequest,
    .phaseCurrent, .supplyVoltage, .vregMv, .nvConfig, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .driveEnable, .driverHighZ, .highSideOn,
    .workingConfig, .nvLoadStrobe
  );
  host_model uHost (.clock, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);
  // Clock, and a cycle ceiling so a hang still reaches the verdict
  initial
  begin
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  // Bounded wait; n tells how many cycles it took
  task automatic waitV(ref logic s, input logic v);
    for (n = 0; n < 64 && s !== v; n++)
    begin
      @(posedge clock);
      #1;
    end
  endtask : waitV
  task automatic rd(input logic [7:0] a);
    uHost.xfer(1'b0, a, 8'h00, rdv);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    uHost.xfer(1'b1, a, d, rdv);
  endtask : wr
  task automatic tFaults();
    @(posedge clock);
    tempAboveLimit <= 1'b1;
    tempBelowRecover <= 1'b0;
    @(posedge clock);
    tempAboveLimit <= 1'b0;
    waitV(driveEnable, 1'b0);
    rd(STATUS_ADDR);
    chk(rdv[OVER_TEMP_BIT] === 1'b1 && driveEnable === 1'b0, "hot");
    @(posedge clock);
    tempBelowRecover <= 1'b1;
    waitV(driveEnable, 1'b1);
    rd(STATUS_ADDR);
    chk(rdv === 8'h00 && driveEnable === 1'b1, "no cool resume");
    @(posedge clock);
    supplyBelowFalling <= 1'b1;
    supplyAboveRising <= 1'b0;
    @(posedge clock);
    supplyBelowFalling <= 1'b0;
    waitV(driveEnable, 1'b0);
    waitV(driveEnable, 1'b1);
    chk(driveEnable === 1'b0, "uv restart early");
    @(posedge clock);
    supplyAboveRising <= 1'b1;
    waitV(driveEnable, 1'b1);
    chk(driveEnable === 1'b1, "uv no restart");
    @(posedge clock);
    phaseOverCurrent <= 1'b1;
    rd(STATUS_ADDR);
    chk(rdv[OVER_CURR_BIT] === 1'b1 && driverHighZ === 1'b1, "oc");
    @(posedge clock);
    phaseOverCurrent <= 1'b0;
    waitV(driveEnable, 1'b1);
    chk(driverHighZ === 1'b0, "hz held");
    $display("fault test done");
  endtask : tFaults
  task automatic tLock();
    @(posedge clock);
    rotorLockDetect <= 1'b1;
    waitV(driveEnable, 1'b0);
    chk(n <= 1, "late stop");
    waitV(driveEnable, 1'b1);
    chk(n >= LK - 1 && n <= LK + 1, "release time");
    waitV(driveEnable, 1'b0);
    chk(n <= 2, "no repeat");
    rd(STATUS_ADDR);
    chk(rdv[ROTOR_LOCK_BIT] === 1'b1 && rdv[3:0] === REASON_LOCK, "lock flag");
    @(posedge clock);
    rotorLockDetect <= 1'b0;
    waitV(driveEnable, 1'b1);
    rd(STATUS_ADDR);
    chk(rdv === 8'h00, "lock stuck");
    $display("lock test done");
  endtask : tLock
  task automatic tConfig();
    @(posedge clock);
    sleepRequest <= 1'b1;
    nvConfig <= 16'hC3A5;
    waitV(driveEnable, 1'b0);
    chk(workingConfig === 16'h5A3C, "early reload");
    @(posedge clock);
    sleepRequest <= 1'b0;
    waitV(nvLoadStrobe, 1'b1);
    chk(workingConfig === 16'hC3A5, "no wake reload");
    wr(CONTROL_ADDR, 8'h02);
    wr(HOSTCFG_LO_ADDR, 8'hAB);
    wr(HOSTCFG_HI_ADDR, 8'hCD);
    chk(workingConfig === 16'hCDAB, "host cfg");
    wr(STATUS_ADDR, 8'hFF);
    rd(STATUS_ADDR);
    chk(rdv === 8'h00, "status written");
    @(posedge clock);
    phaseCurrent <= 8'h3E;
    rd(CURRENT_ADDR);
    chk(rdv === 8'h3E, "current");
    rd(8'h30);
    chk(rdv === READ_UNMAPPED, "unmapped");
    wr(CONTROL_ADDR, 8'h00);
    chk(workingConfig === nvConfig, "nv back");
    $display("config test done");
  endtask : tConfig
  task automatic tBuck();
    @(posedge clock);
    vregMv <= VREG_5V_MV - VREG_HYS_MV - 16'h0001;
    waitV(highSideOn, 1'b1);
    chk(highSideOn === 1'b1, "no switch 5 V");
    @(posedge clock);
    vregMv <= VREG_5V_MV;
    waitV(highSideOn, 1'b0);
    chk(highSideOn === 1'b0, "stuck on");
    wr(CONTROL_ADDR, 8'h01);
    @(posedge clock);
    vregMv <= VREG_3V3_MV + 16'h0064;
    waitV(highSideOn, 1'b1);
    chk(highSideOn === 1'b0, "wrong target");
    @(posedge clock);
    vregMv <= VREG_3V3_MV - VREG_HYS_MV - 16'h0001;
    waitV(highSideOn, 1'b1);
    chk(highSideOn === 1'b1, "no switch 3.3 V");
    $display("buck test done");
  endtask : tBuck
  // Any window of one sample period holds a supply capture
  task automatic tSupply();
    @(posedge clock);
    supplyVoltage <= 8'h6B;
    repeat (VSUP_SAMPLE_CYCLES) @(posedge clock);
    rd(SUPPLY_ADDR);
    chk(rdv === 8'h6B, "supply not sampled");
    $display("supply test done");
  endtask : tSupply
  // Main sequence: reset, power-on load, then each scenario
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 chk(nvLoadStrobe === 1'b1 && workingConfig === nvConfig, "boot load");
    waitV(driveEnable, 1'b1);
    tFaults();
    tLock();
    tConfig();
    tBuck();
    tSupply();
    close_out();
  end
endmodule : tb
